// ---- src/irq_route_pkg.sv ----
// constants, register map and shared types for the dual-core interrupt router
// assumes a single 10 MHz clock, active-low asynchronous reset, AXI4-Lite register access
//
// What this block does
// - each core's controller has 32 interrupt inputs, same sources except gpio bank
// - gpio bank interrupt for each core is generated independently per core
// - only inputs 0 to 25 come from peripherals; 26 to 31 are tied low
// - software pending set for inputs 26 to 31 still enters the handler
// - inputs 0-3 timers, 4 pwm wrap, 5 usb, 6 execute-in-place, 7-10 programmable io
// - 11-12 dma, 13 gpio bank, 14 qspi, 15-16 core io, 17 clocks, 18-25 serial, adc, rtc
// - input 6 comes from the synchronous serial interface of execute-in-place block
// - higher-priority pending interrupt preempts a running lower-priority handler, which resumes later
// - priority uses top two bits of an 8-bit field; level 0 most urgent
// - on equal priority level the lower interrupt number wins
// - each core's nonmaskable interrupt is OR of the 26 lines ANDed with its mask
// - two nonmaskable mask registers, one per core, one bit per system interrupt
// - inputs accept both level-sensitive and pulse-sensitive interrupt lines
package irq_route_pkg;
	localparam int num_inputs = 32;
	localparam int num_sys = 26;
	localparam int num_pri_levels = 4;
	localparam int prio_width = 8;
	localparam int prio_msb = 7;
	localparam int prio_lsb = 6;
	localparam int gpio_bank_input = 13;
	localparam int xip_input = 6;
	localparam int core_io0_input = 15;
	localparam int core_io1_input = 16;
	// register map, byte addresses
	localparam logic [7:0] addr_enable0 = 8'h00;
	localparam logic [7:0] addr_enable1 = 8'h04;
	localparam logic [7:0] addr_pending_set0 = 8'h08;
	localparam logic [7:0] addr_pending_set1 = 8'h0c;
	localparam logic [7:0] addr_pending_clr0 = 8'h10;
	localparam logic [7:0] addr_pending_clr1 = 8'h14;
	localparam logic [7:0] addr_pending0 = 8'h18;
	localparam logic [7:0] addr_pending1 = 8'h1c;
	localparam logic [7:0] addr_core0_nonmaskable_mask = 8'h20;
	localparam logic [7:0] addr_core1_nonmaskable_mask = 8'h24;
	localparam logic [7:0] addr_active0 = 8'h28;
	localparam logic [7:0] addr_active1 = 8'h2c;
	localparam logic [7:0] addr_complete0 = 8'h30;
	localparam logic [7:0] addr_complete1 = 8'h34;
	localparam logic [7:0] addr_irq_status = 8'h38;
	localparam logic [7:0] addr_irq_enable = 8'h3c;
	localparam logic [7:0] addr_irq_clear = 8'h40;
	localparam logic [7:0] addr_prio_base0 = 8'h80; // 8 words per core
	localparam logic [7:0] addr_prio_base1 = 8'ha0;
	localparam logic [31:0] mask_reset = 32'h0000_0000;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
	localparam logic [4:0] no_irq = 5'h1f;
	typedef struct packed {
		logic take;
		logic [4:0] num;
		logic [1:0] level;
	} pick_type;
endpackage

// ---- src/irq_arb_if.sv ----
// carrier between the router top and the per-core arbiter
// assumes both ends run on the same clock
interface irq_arb_if;
	logic [31:0] pending;
	logic [31:0] enable;
	logic [63:0] levels;
	logic [2:0] running;
	logic take;
	logic [4:0] num;
	logic [1:0] level;
	modport router (output pending, enable, levels, running, input take, num, level);
	modport arbiter (input pending, enable, levels, running, output take, num, level);
endinterface

// ---- src/irq_core_arb.sv ----
// per-core priority pick: lowest level first, then lowest number
// purely combinational; the top registers its outputs
module irq_core_arb
	import irq_route_pkg::*;
(
	irq_arb_if.arbiter arb // request and answer of one core
);
	always_comb begin
		logic [2:0] best;
		best = 3'h4;
		arb.take = 1'b0;
		arb.num = no_irq;
		arb.level = 2'h3;
		for (int i = 0; i < num_inputs; i++) begin
			// strict less keeps the lower number on ties
			if (arb.pending[i] && arb.enable[i] && {1'b0, arb.levels[2*i +: 2]} < best) begin
				best = {1'b0, arb.levels[2*i +: 2]};
				arb.num = 5'(i);
				arb.level = arb.levels[2*i +: 2];
			end
		end
		// preempt only when strictly more urgent than the running level
		arb.take = (best < arb.running);
	end
endmodule // irq_core_arb

// ---- src/irq_router.sv ----
// dual-core interrupt router with priority pick, preemption stack and nonmaskable generation
// assumes the core acknowledges a delivered interrupt by writing the complete register
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
module irq_router
	import irq_route_pkg::*;
(
	input wire logic clk, // 10 MHz
	input wire logic rstn, // async reset, active low
	input wire logic [num_sys-1:0] sys_irq, // peripheral lines, gpio bank slot unused
	input wire logic [1:0] gpio_bank_irq, // per-core gpio bank interrupt
	input wire logic [num_sys-1:0] pulse_mode, // 1: line is pulse, 0: level
	input wire logic [31:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [31:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read valid
	input wire logic s_axi_rready, // read ready
	output logic [1:0] core_irq, // interrupt request per core
	output logic [9:0] core_irq_num, // 5-bit vector per core
	output logic [1:0] core_nmi, // nonmaskable per core
	output logic irq // block event interrupt
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [31:0] enable [2];
	logic [31:0] pending [2];
	logic [31:0] active [2];
	logic [7:0] prio [2][num_inputs];
	logic [num_sys-1:0] core0_nonmaskable_mask;
	logic [num_sys-1:0] core1_nonmaskable_mask;
	logic [num_sys-1:0] line_prev [2];
	logic [1:0] irq_status;
	logic [1:0] irq_enable;
	logic [31:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic have_aw;
	logic have_w;
	pick_type pick [2];

	function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (s[b]) r[8*b +: 8] = d[8*b +: 8];
		return r;
	endfunction

	// highest running level of a core: lowest level among active handlers, 4 when idle
	function automatic logic [2:0] running_level(input logic [31:0] act, input int c);
		logic [2:0] r;
		r = 3'h4;
		for (int i = 0; i < num_inputs; i++)
			if (act[i] && {1'b0, prio[c][i][prio_msb:prio_lsb]} < r)
				r = {1'b0, prio[c][i][prio_msb:prio_lsb]};
		return r;
	endfunction

	// ---------------------------------------------------------------
	// per-core source vectors
	// ---------------------------------------------------------------
	logic [31:0] line [2];
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			line[c] = 32'h0; // 26..31 stay low from hardware
			line[c][num_sys-1:0] = sys_irq; // same sources to both cores, 0..25 numbering
			line[c][gpio_bank_input] = gpio_bank_irq[c]; // independent per core
		end
	end

	// ---------------------------------------------------------------
	// arbiters
	// ---------------------------------------------------------------
	irq_arb_if arb0 ();
	irq_arb_if arb1 ();
	irq_core_arb u_arb0 (.arb(arb0));
	irq_core_arb u_arb1 (.arb(arb1));
	always_comb begin
		arb0.pending = pending[0];
		arb1.pending = pending[1];
		arb0.enable = enable[0];
		arb1.enable = enable[1];
		for (int i = 0; i < num_inputs; i++) begin
			arb0.levels[2*i +: 2] = prio[0][i][prio_msb:prio_lsb];
			arb1.levels[2*i +: 2] = prio[1][i][prio_msb:prio_lsb];
		end
		arb0.running = running_level(active[0], 0);
		arb1.running = running_level(active[1], 1);
		pick[0] = '{take: arb0.take, num: arb0.num, level: arb0.level};
		pick[1] = '{take: arb1.take, num: arb1.num, level: arb1.level};
	end

	// ---------------------------------------------------------------
	// axi4-lite slave
	// ---------------------------------------------------------------
	wire do_write = have_aw && have_w && !s_axi_bvalid;
	wire do_read = s_axi_arvalid && s_axi_arready;
	wire [7:0] waddr = wr_addr[7:0];
	wire wmapped = (wr_addr[31:8] == 24'h0) && (wr_addr[1:0] == 2'h0);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			have_aw <= 1'b0;
			have_w <= 1'b0;
			wr_addr <= 32'h0;
			wr_data <= 32'h0;
			wr_strb <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= resp_okay;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				have_aw <= 1'b1;
				wr_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				have_w <= 1'b1;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				have_aw <= 1'b0;
				have_w <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wmapped ? resp_okay : resp_slverr;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= resp_okay;
		end else begin
			if (do_read) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= resp_okay;
				s_axi_rdata <= 32'h0;
				if (s_axi_araddr[31:8] != 24'h0 || s_axi_araddr[1:0] != 2'h0)
					s_axi_rresp <= resp_slverr;
				else if (s_axi_araddr[7] == 1'b1)
					for (int b = 0; b < 4; b++)
						s_axi_rdata[8*b +: 8] <= prio[s_axi_araddr[5]][{s_axi_araddr[4:2], 2'(b)}];
				else
					unique case (s_axi_araddr[7:0])
						addr_enable0: s_axi_rdata <= enable[0];
						addr_enable1: s_axi_rdata <= enable[1];
						addr_pending0, addr_pending_set0: s_axi_rdata <= pending[0];
						addr_pending1, addr_pending_set1: s_axi_rdata <= pending[1];
						addr_core0_nonmaskable_mask: s_axi_rdata <= 32'(core0_nonmaskable_mask);
						addr_core1_nonmaskable_mask: s_axi_rdata <= 32'(core1_nonmaskable_mask);
						addr_active0: s_axi_rdata <= active[0];
						addr_active1: s_axi_rdata <= active[1];
						addr_irq_status: s_axi_rdata <= 32'(irq_status);
						addr_irq_enable: s_axi_rdata <= 32'(irq_enable);
						addr_pending_clr0, addr_pending_clr1, addr_complete0, addr_complete1,
						addr_irq_clear: s_axi_rdata <= 32'h0;
						default: s_axi_rresp <= resp_slverr;
					endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			enable[0] <= 32'h0;
			enable[1] <= 32'h0;
			core0_nonmaskable_mask <= num_sys'(mask_reset);
			core1_nonmaskable_mask <= num_sys'(mask_reset);
			irq_enable <= 2'h0;
			for (int c = 0; c < 2; c++)
				for (int i = 0; i < num_inputs; i++)
					prio[c][i] <= 8'h00;
		end else if (do_write && wmapped) begin
			if (waddr[7])
				for (int b = 0; b < 4; b++)
					if (wr_strb[b]) prio[waddr[5]][{waddr[4:2], 2'(b)}] <= wr_data[8*b +: 8];
			unique case (waddr)
				addr_enable0: enable[0] <= byte_merge(enable[0], wr_data, wr_strb);
				addr_enable1: enable[1] <= byte_merge(enable[1], wr_data, wr_strb);
				addr_core0_nonmaskable_mask: core0_nonmaskable_mask <=
					num_sys'(byte_merge(32'(core0_nonmaskable_mask), wr_data, wr_strb));
				addr_core1_nonmaskable_mask: core1_nonmaskable_mask <=
					num_sys'(byte_merge(32'(core1_nonmaskable_mask), wr_data, wr_strb));
				addr_irq_enable: irq_enable <= wr_data[1:0];
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// pending, active and delivery per core
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int c = 0; c < 2; c++) begin
				pending[c] <= 32'h0;
				active[c] <= 32'h0;
				line_prev[c] <= '0;
			end
			core_irq <= 2'h0;
			core_irq_num <= 10'h0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				logic [31:0] set;
				logic [31:0] clr;
				logic [31:0] lvl;
				set = 32'h0;
				clr = 32'h0;
				line_prev[c] <= line[c][num_sys-1:0];
				// pulse lines latch on a rising edge, level lines set pending in every cycle the line is high
				for (int i = 0; i < num_sys; i++)
					set[i] = pulse_mode[i] ? (line[c][i] && !line_prev[c][i]) : line[c][i];
				if (do_write && wmapped && waddr == (c == 0 ? addr_pending_set0 : addr_pending_set1))
					set = set | wr_data; // reaches 26..31 too
				if (do_write && wmapped && waddr == (c == 0 ? addr_pending_clr0 : addr_pending_clr1))
					clr = wr_data;
				if (pick[c].take)
					clr[pick[c].num] = 1'b1;
				lvl = (pending[c] & ~clr) | set; // set wins over clear
				pending[c] <= lvl;
				if (pick[c].take)
					active[c][pick[c].num] <= 1'b1; // nested on top of lower handler
				if (do_write && wmapped && waddr == (c == 0 ? addr_complete0 : addr_complete1))
					active[c] <= (pick[c].take ? (active[c] | (32'h1 << pick[c].num)) : active[c]) & ~wr_data;
				core_irq[c] <= pick[c].take;
				if (pick[c].take)
					core_irq_num[5*c +: 5] <= pick[c].num;
			end
		end
	end

	// ---------------------------------------------------------------
	// nonmaskable and block event interrupt
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			core_nmi <= 2'h0;
		end else begin
			core_nmi[0] <= |(line[0][num_sys-1:0] & core0_nonmaskable_mask);
			core_nmi[1] <= |(line[1][num_sys-1:0] & core1_nonmaskable_mask);
		end
	end

	// status bit per core: a delivery happened; a set wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_status <= 2'h0;
			irq <= 1'b0;
		end else begin
			logic [1:0] clr;
			clr = (do_write && wmapped && waddr == addr_irq_clear) ? wr_data[1:0] : 2'h0;
			irq_status <= (irq_status & ~clr) | {pick[1].take, pick[0].take};
			irq <= |(((irq_status & ~clr) | {pick[1].take, pick[0].take}) & irq_enable);
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	// inputs of core 0 at the most urgent level; lower numbers at other levels may legally wait
	logic [31:0] urgent0;
	always_comb begin
		for (int i = 0; i < num_inputs; i++)
			urgent0[i] = (prio[0][i][prio_msb:prio_lsb] == 2'h0);
	end
	chk_nmi_follows_mask: assert property (@(posedge clk) disable iff (!rstn)
		core_nmi[0] == $past(|(line[0][num_sys-1:0] & core0_nonmaskable_mask)))
		else $error("core0 nonmaskable does not follow masked lines");
	chk_nmi_reset_quiet: assert property (@(posedge clk) disable iff (!rstn)
		$rose(rstn) |-> core_nmi == 2'h0)
		else $error("nonmaskable active right after reset");
	chk_high_inputs_tied: assert property (@(posedge clk) disable iff (!rstn)
		line[0][31:num_sys] == '0 && line[1][31:num_sys] == '0)
		else $error("inputs 26 to 31 driven by hardware");
	chk_gpio_per_core: assert property (@(posedge clk) disable iff (!rstn)
		line[1][gpio_bank_input] == gpio_bank_irq[1] && line[0][gpio_bank_input] == gpio_bank_irq[0])
		else $error("gpio bank line not per core");
	chk_take_preempts: assert property (@(posedge clk) disable iff (!rstn)
		pick[0].take |-> {1'b0, pick[0].level} < arb0.running ##1 core_irq[0] && active[0][$past(pick[0].num)])
		else $error("delivery without preemption or activation");
	chk_take_lowest: assert property (@(posedge clk) disable iff (!rstn)
		(pick[0].take && pick[0].level == 2'h0) |->
			(pending[0] & enable[0] & urgent0 & ((32'h1 << pick[0].num) - 32'h1)) == 32'h0)
		else $error("lower number at level 0 overlooked");
	chk_soft_pending: assert property (@(posedge clk) disable iff (!rstn)
		(do_write && wmapped && waddr == addr_pending_set0 && wr_data[31]) |=> pending[0][31] || active[0][31])
		else $error("software pending for input 31 lost");
	chk_irq_enable_gate: assert property (@(posedge clk) disable iff (!rstn)
		irq |-> $past(irq_enable) != 2'h0)
		else $error("event interrupt raised while disabled");
endmodule // irq_router

// ---- testbench/irq_far_side.sv ----
// model of what sits around the router: the peripheral lines and the two cores
// assumes the bench calls drive() for line changes and reads the delivery log
module irq_far_side
	import irq_route_pkg::*;
(
	input wire logic clk, // bench clock
	input wire logic rstn, // async reset, active low
	output logic [num_sys-1:0] sys_irq, // peripheral lines by number
	output logic [1:0] gpio_bank_irq, // gpio bank line per core
	output logic [num_sys-1:0] pulse_mode, // line kind per input
	input wire logic [1:0] core_irq, // delivery pulse per core
	input wire logic [9:0] core_irq_num, // delivered vector per core
	output logic [1:0][7:0] take_cnt, // deliveries seen per core
	output logic [1:0][4:0] last_num // last vector seen per core
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		sys_irq = '0;
		gpio_bank_irq = '0;
		pulse_mode = '0;
	end
	// -----------------------------------------------
	// peripheral side
	// -----------------------------------------------
	// lines change only after an edge; every line, a pulse line included, holds until the next drive()
	task automatic drive(input logic [num_sys-1:0] s, input logic [1:0] g, input logic [num_sys-1:0] m);
		@(posedge clk);
		sys_irq <= s;
		gpio_bank_irq <= g;
		pulse_mode <= m;
	endtask
	// -----------------------------------------------
	// core side
	// -----------------------------------------------
	// each core logs the vector it enters; the bench acknowledges through the complete register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			take_cnt <= '0;
			last_num <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (core_irq[c]) begin
					take_cnt[c] <= take_cnt[c] + 8'h01;
					last_num[c] <= core_irq_num[c*5 +: 5];
				end
			end
		end
	end
endmodule // irq_far_side

// ---- testbench/irq_router_test.sv ----
// self-checking bench for the dual-core interrupt router
// assumes the router answers on its AXI4-Lite port and irq_far_side plays lines and cores
module irq_router_test;
	import irq_route_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
	logic [3:0] wstrb = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp, core_irq, core_nmi;
	logic [31:0] rdata;
	logic [9:0] core_irq_num;
	logic [num_sys-1:0] sys_irq, pulse_mode;
	logic [1:0] gpio_bank_irq;
	logic [1:0][7:0] take_cnt;
	logic [1:0][4:0] last_num;
	logic [7:0] got [2] = '{8'h00, 8'h00};
	int error_cnt = 0;
	int num_checks = 0;
	always #50 clk = ~clk;
	irq_router dut (.clk(clk), .rstn(rstn), .sys_irq(sys_irq), .gpio_bank_irq(gpio_bank_irq),
		.pulse_mode(pulse_mode), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_irq(core_irq), .core_irq_num(core_irq_num),
		.core_nmi(core_nmi), .irq(irq));
	irq_far_side far (.clk(clk), .rstn(rstn), .sys_irq(sys_irq), .gpio_bank_irq(gpio_bank_irq),
		.pulse_mode(pulse_mode), .core_irq(core_irq), .core_irq_num(core_irq_num), .take_cnt(take_cnt),
		.last_num(last_num));
	// -----------------------------------------------
	// helpers
	// -----------------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	task automatic give_up();
		error_cnt++;
		$display("[FAIL] t=%0t wait ran out", $time);
		stop_test();
	endtask
	// payloads stay put until their own ready edge; bready is held until bvalid is seen
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		awaddr <= {24'h000000, a};
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		if (i == 50) give_up();
		bready <= 1'b0;
		check({30'h0, bresp}, {30'h0, resp_okay});
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		@(posedge clk);
		araddr <= {24'h000000, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		if (i == 50) give_up();
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		check(d, exp);
	endtask
	// waits for the next delivery on core c and compares its vector
	task automatic take(input int c, input logic [4:0] n);
		int i;
		for (i = 0; i < 30; i++) begin
			if (take_cnt[c] !== got[c]) break;
			@(posedge clk);
		end
		if (i == 30) give_up();
		got[c] = got[c] + 8'h01;
		check({27'h0, last_num[c]}, {27'h0, n});
	endtask
	task automatic quiet(input int c);
		repeat (6) @(posedge clk);
		check({24'h0, take_cnt[c]}, {24'h0, got[c]});
	endtask
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		// -----------------------------------------------
		// reset state and refusal
		// -----------------------------------------------
		rd_chk(addr_core0_nonmaskable_mask, mask_reset);
		rd_chk(addr_core1_nonmaskable_mask, mask_reset);
		rd(8'h44, d, r);
		check({30'h0, r}, {30'h0, resp_slverr});
		// -----------------------------------------------
		// line mapping and per-core gpio bank
		// -----------------------------------------------
		far.drive(26'h3ff_ffff, 2'b01, 26'h000_0000);
		repeat (3) @(posedge clk);
		rd_chk(addr_pending0, 32'h03ff_ffff);
		rd_chk(addr_pending1, 32'h03ff_dfff);
		// nonmaskable: masked OR of the system lines, separately per core
		wr(addr_core0_nonmaskable_mask, 32'h0000_0040);
		wr(addr_core1_nonmaskable_mask, 32'h0010_0000);
		repeat (3) @(posedge clk);
		check({30'h0, core_nmi}, 32'h3);
		far.drive(26'h3ef_ffff, 2'b01, 26'h000_0000);
		repeat (3) @(posedge clk);
		check({30'h0, core_nmi}, 32'h1);
		rd_chk(addr_core1_nonmaskable_mask, 32'h0010_0000);
		// pending is sticky; after a clear a high level line pends again, a held pulse line does not
		far.drive(26'h000_0000, 2'b00, 26'h000_0010);
		wr(addr_pending_clr0, 32'hffff_ffff);
		wr(addr_pending_clr1, 32'hffff_ffff);
		far.drive(26'h000_0030, 2'b00, 26'h000_0010);
		repeat (3) @(posedge clk);
		check({30'h0, core_nmi}, 32'h0);
		rd_chk(addr_pending0, 32'h0000_0030);
		wr(addr_pending_clr0, 32'h0000_0030);
		rd_chk(addr_pending0, 32'h0000_0020);
		far.drive(26'h000_0000, 2'b00, 26'h000_0010);
		wr(addr_pending_clr0, 32'h0000_0020);
		rd_chk(addr_pending0, 32'h0000_0000);
		// -----------------------------------------------
		// priority order and preemption on core 0
		// -----------------------------------------------
		wr(addr_prio_base0, 32'h7f00_0000); // input 3 at level 1, low bits ignored
		wr(addr_enable0, 32'h8000_068d);
		wr(addr_pending_set0, 32'h0000_0408);
		take(0, 5'd10);
		wr(addr_pending_set0, 32'h0000_0004);
		quiet(0);
		rd_chk(addr_active0, 32'h0000_0400);
		wr(addr_complete0, 32'h0000_0400);
		take(0, 5'd2);
		wr(addr_complete0, 32'h0000_0004);
		take(0, 5'd3);
		wr(addr_pending_set0, 32'h0000_0001);
		take(0, 5'd0);
		wr(addr_complete0, 32'h0000_0001);
		quiet(0);
		wr(addr_complete0, 32'h0000_0008);
		wr(addr_pending_set0, 32'h0000_0280);
		take(0, 5'd7);
		wr(addr_complete0, 32'h0000_0080);
		take(0, 5'd9);
		wr(addr_complete0, 32'h0000_0200);
		wr(addr_pending_set0, 32'h8000_0000);
		take(0, 5'd31);
		wr(addr_complete0, 32'h8000_0000);
		// core 1 software pending, core 0 untouched
		wr(addr_enable1, 32'h0400_0000);
		wr(addr_pending_set1, 32'h0400_0000);
		take(1, 5'd26);
		quiet(0);
		wr(addr_complete1, 32'h0400_0000);
		// -----------------------------------------------
		// block event interrupt: masked, enabled, cleared
		// -----------------------------------------------
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		rd_chk(addr_irq_status, 32'h0000_0003);
		wr(addr_irq_enable, 32'h0000_0001);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h1);
		wr(addr_irq_clear, 32'h0000_0001);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		rd_chk(addr_irq_status, 32'h0000_0002);
		// a reset of the configuration in mid-run clears a stale core 1 mask
		wr(addr_core1_nonmaskable_mask, 32'h0000_0001);
		far.drive(26'h000_0001, 2'b00, 26'h000_0000);
		repeat (3) @(posedge clk);
		check({30'h0, core_nmi}, 32'h2);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd_chk(addr_core1_nonmaskable_mask, mask_reset);
		check({30'h0, core_nmi}, 32'h0);
		stop_test();
	end
endmodule // irq_router_test
